/* File: hw/fnd_consts.vh */
// constants for the fractional-N divider control and lock status slice
// Overview of operation
// - 24-bit resolution: high byte over low halfword forms signed offset over 2^24.
// - 16-bit resolution: high byte ignored, low halfword alone signed over 2^16.
// - Integer-N mode: both fractional registers ignored, divide by integer only.
// - Status bit 7 mirrors live lock output, never latched.
// - Status bits 6 to 2 always read zero.
// - In-lock flag needs control bit 6; control bit 4 picks edge or level.
// - Edge mode: in-lock flag sets on lock rising, clears on status read.
// - Level mode: in-lock held while lock and enable; read clears otherwise.
// - Reset-lock via detector config bit 13 clears the in-lock flag.
// - Out-of-lock flag needs control bit 5; edge mode sets on lock falling.
// - Level mode: out-of-lock held while unlocked and enabled; read clears otherwise.
// - Reset-lock clears the out-of-lock flag.
// - Both flags ORed toward the main device status register.
// - Control bit 8 powers up; charge pump stays off until first divider load.
// - Integer-N: integer register write takes effect at once.
// - Fractional modes: integer and high byte staged, low halfword write commits.
// - New ratio taking effect starts fastlock when fastlock is enabled.
// - Analogue or digital lock detector selectable; both synthesisers identical.
// - Detector config bit 14: 0 digital, 1 analogue.
// - Digital detector locks after 1..32 consecutive in-phase pulses, zero meaning 32.
`ifndef FND_CONSTS_VH
`define FND_CONSTS_VH

// register offsets, synthesiser 1
`define FND_S1_CONTROL 8'h4e
`define FND_S1_LOCKDET 8'h4f
`define FND_S1_FASTACQ 8'h50
`define FND_S1_REFDIV 8'h52
`define FND_S1_INTDIV 8'h53
`define FND_S1_FRACLO 8'h54
`define FND_S1_FRACHI 8'h55
`define FND_S1_FLAGS 8'h56
// register offsets, synthesiser 2
`define FND_S2_CONTROL 8'h57
`define FND_S2_LOCKDET 8'h58
`define FND_S2_FASTACQ 8'h59
`define FND_S2_REFDIV 8'h5b
`define FND_S2_INTDIV 8'h5c
`define FND_S2_FRACLO 8'h5d
`define FND_S2_FRACHI 8'h5e
`define FND_S2_FLAGS 8'h5f

// reset values
`define FND_RST_INTDIV 11'h020
`define FND_RST_ZERO16 16'h0000

// control register fields
`define FND_CON_RES16 14
`define FND_CON_MOD_HI 13
`define FND_CON_MOD_LO 11
`define FND_CON_ENABLE 8
`define FND_CON_INLOCK_EN 6
`define FND_CON_OUTLOCK_EN 5
`define FND_CON_LEVEL 4
`define FND_MOD_INTEGER 3'h0

// lock detector config fields
`define FND_LD_ANALOGUE 14
`define FND_LD_RESET_LOCK 13

// fastlock config fields
`define FND_FA_ENABLE 12

// status register fields
`define FND_ST_LOCK 7
`define FND_ST_INLOCK 1
`define FND_ST_OUTLOCK 0

`endif

/* File: hw/fnd_dig_lock.v */
// digital lock detector: consecutive in-phase / out-of-phase pulse counter
`timescale 1ns/1ps
module fnd_dig_lock #(
  parameter CNT_W = 6
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // phase comparison pulses
  input wire in_phase_in,
  input wire out_phase_in,
  // thresholds and clear
  input wire [4:0] lock_thresh_in,
  input wire [2:0] loss_thresh_in,
  input wire clear_in,
  // lock indicator
  output wire lock_out
);

  reg lock_q;
  reg [CNT_W-1:0] cnt_q;
  wire [CNT_W-1:0] lock_lim;
  wire [CNT_W-1:0] loss_lim;
  wire [CNT_W-1:0] cnt_inc;

  // a zero field means the largest count
  function [CNT_W-1:0] expand;
    input [4:0] val;
    input [CNT_W-1:0] top;
    begin
      if (val == 5'h00) begin
        expand = top;
      end else begin
        expand = {{(CNT_W-5){1'b0}}, val};
      end
    end
  endfunction

  assign lock_lim = expand(lock_thresh_in, 6'h20);
  assign loss_lim = expand({2'b00, loss_thresh_in}, 6'h08);
  assign cnt_inc = cnt_q + 6'h01;
  assign lock_out = lock_q;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      lock_q <= 1'b0;
      cnt_q <= 6'h00;
    end else if (!lock_q) begin
      if (out_phase_in) begin
        cnt_q <= 6'h00;
      end else if (in_phase_in) begin
        if (cnt_inc >= lock_lim) begin
          lock_q <= 1'b1;
          cnt_q <= 6'h00;
        end else begin
          cnt_q <= cnt_inc;
        end
      end
    end else begin
      if (in_phase_in) begin
        cnt_q <= 6'h00;
      end else if (out_phase_in) begin
        if (cnt_inc >= loss_lim) begin
          lock_q <= 1'b0;
          cnt_q <= 6'h00;
        end else begin
          cnt_q <= cnt_inc;
        end
      end
    end
  end

endmodule

/* File: hw/fnd_synth_ctrl.v */
// one synthesiser slice: divider staging, mode decode, lock flags, register port
`timescale 1ns/1ps
`include "fnd_consts.vh"
module fnd_synth_ctrl #(
  parameter SYNTH_SEL = 1
) (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // register port from the serial control decoder
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] addr_in,
  input wire [15:0] wdata_in,
  output reg [15:0] rdata_out,
  output reg rvalid_out,
  // lock detector inputs
  input wire analog_lock_in,
  input wire in_phase_in,
  output wire dummy_unused_out,
  input wire out_phase_in,
  // divider and analogue control
  output reg [10:0] ratio_int_out,
  output reg [23:0] ratio_frac_out,
  output wire frac_mode_out,
  output wire power_up_out,
  output wire cp_enable_out,
  output wire [3:0] cp_current_out,
  output wire [6:0] ref_div_out,
  output wire [11:0] fastacq_cfg_out,
  output wire fastlock_start_out,
  // lock status
  output wire lock_out,
  output wire flag_any_out
);

  ////////////////////////////////////////////////////////////////////////////
  // address map for this instance
  wire [7:0] a_con = (SYNTH_SEL == 2) ? `FND_S2_CONTROL : `FND_S1_CONTROL;
  wire [7:0] a_ld = (SYNTH_SEL == 2) ? `FND_S2_LOCKDET : `FND_S1_LOCKDET;
  wire [7:0] a_fa = (SYNTH_SEL == 2) ? `FND_S2_FASTACQ : `FND_S1_FASTACQ;
  wire [7:0] a_rd = (SYNTH_SEL == 2) ? `FND_S2_REFDIV : `FND_S1_REFDIV;
  wire [7:0] a_id = (SYNTH_SEL == 2) ? `FND_S2_INTDIV : `FND_S1_INTDIV;
  wire [7:0] a_fl = (SYNTH_SEL == 2) ? `FND_S2_FRACLO : `FND_S1_FRACLO;
  wire [7:0] a_fh = (SYNTH_SEL == 2) ? `FND_S2_FRACHI : `FND_S1_FRACHI;
  wire [7:0] a_st = (SYNTH_SEL == 2) ? `FND_S2_FLAGS : `FND_S1_FLAGS;

  wire wr_con = wr_en_in && (addr_in == a_con);
  wire wr_ld = wr_en_in && (addr_in == a_ld);
  wire wr_fa = wr_en_in && (addr_in == a_fa);
  wire wr_rd = wr_en_in && (addr_in == a_rd);
  wire wr_id = wr_en_in && (addr_in == a_id);
  wire wr_fl = wr_en_in && (addr_in == a_fl);
  wire wr_fh = wr_en_in && (addr_in == a_fh);
  wire rd_st = rd_en_in && (addr_in == a_st);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  reg [15:0] con_q;
  reg [15:0] ld_q;
  reg [15:0] fa_q;
  reg [6:0] rdiv_q;
  reg [10:0] int_stage_q;
  reg [7:0] hi_stage_q;
  reg [15:0] lo_stage_q;
  reg loaded_q;
  reg fl_start_q;
  reg lock_prev_q;
  reg inlock_q;
  reg outlock_q;

  wire int_mode = (con_q[`FND_CON_MOD_HI:`FND_CON_MOD_LO] == `FND_MOD_INTEGER);
  wire res16 = con_q[`FND_CON_RES16];
  wire reset_lock = wr_ld && wdata_in[`FND_LD_RESET_LOCK];

  // commit point: integer write in integer-N, low halfword write otherwise
  wire commit_int = wr_id && int_mode;
  wire commit_frac = wr_fl && !int_mode;
  wire commit = commit_int || commit_frac;

  // fractional word as seen by the modulator, scaled to 24 bits
  function [23:0] frac_word;
    input integer_n;
    input half_res;
    input [7:0] hi;
    input [15:0] lo;
    begin
      if (integer_n) begin
        frac_word = 24'h000000;
      end else if (half_res) begin
        frac_word = {lo, 8'h00};
      end else begin
        frac_word = {hi, lo};
      end
    end
  endfunction

  always @(posedge clk_in) begin
    if (rst_in) begin
      con_q <= `FND_RST_ZERO16;
      ld_q <= `FND_RST_ZERO16;
      fa_q <= `FND_RST_ZERO16;
      rdiv_q <= 7'h00;
      int_stage_q <= `FND_RST_INTDIV;
      hi_stage_q <= 8'h00;
      lo_stage_q <= `FND_RST_ZERO16;
      ratio_int_out <= `FND_RST_INTDIV;
      ratio_frac_out <= 24'h000000;
      loaded_q <= 1'b0;
      fl_start_q <= 1'b0;
    end else begin
      if (wr_con) begin
        con_q <= wdata_in;
      end
      if (wr_ld) begin
        // reset-lock is an action, not a stored setting
        ld_q <= {wdata_in[15:14], 1'b0, wdata_in[12:0]};
      end
      if (wr_fa) begin
        fa_q <= wdata_in;
      end
      if (wr_rd) begin
        rdiv_q <= wdata_in[6:0];
      end
      if (wr_id) begin
        int_stage_q <= wdata_in[10:0];
      end
      if (wr_fh) begin
        hi_stage_q <= wdata_in[7:0];
      end
      if (wr_fl) begin
        lo_stage_q <= wdata_in;
      end
      if (commit_int) begin
        ratio_int_out <= wdata_in[10:0];
        ratio_frac_out <= 24'h000000;
      end else if (commit_frac) begin
        ratio_int_out <= int_stage_q;
        ratio_frac_out <= frac_word(1'b0, res16, hi_stage_q, wdata_in);
      end
      if (commit) begin
        loaded_q <= 1'b1;
      end
      fl_start_q <= commit && fa_q[`FND_FA_ENABLE];
    end
  end

  assign frac_mode_out = !int_mode;
  assign power_up_out = con_q[`FND_CON_ENABLE];
  // charge pump held off until a first ratio has been committed
  assign cp_enable_out = con_q[`FND_CON_ENABLE] && loaded_q;
  assign cp_current_out = con_q[3:0];
  assign ref_div_out = rdiv_q;
  assign fastacq_cfg_out = fa_q[11:0];
  assign fastlock_start_out = fl_start_q;
  assign dummy_unused_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // lock detection
  wire dig_lock;

  fnd_dig_lock #(
    .CNT_W(6)
  ) u_dig_lock (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_phase_in(in_phase_in),
    .out_phase_in(out_phase_in),
    .lock_thresh_in(ld_q[4:0]),
    .loss_thresh_in(ld_q[7:5]),
    .clear_in(reset_lock),
    .lock_out(dig_lock)
  );

  assign lock_out = ld_q[`FND_LD_ANALOGUE] ? analog_lock_in : dig_lock;

  ////////////////////////////////////////////////////////////////////////////
  // sticky lock flags; a set in the read cycle survives the read
  wire in_en = con_q[`FND_CON_INLOCK_EN];
  wire out_en = con_q[`FND_CON_OUTLOCK_EN];
  wire level = con_q[`FND_CON_LEVEL];
  wire rise = lock_out && !lock_prev_q;
  wire fall = !lock_out && lock_prev_q;
  reg inlock_d;
  reg outlock_d;

  always @* begin
    if (level) begin
      inlock_d = (lock_out && in_en) ||
        (inlock_q && !(rd_st && (!lock_out || !in_en)));
      outlock_d = (!lock_out && out_en) ||
        (outlock_q && !(rd_st && (lock_out || !out_en)));
    end else begin
      inlock_d = (rise && in_en) || (inlock_q && !rd_st);
      outlock_d = (fall && out_en) || (outlock_q && !rd_st);
    end
    if (reset_lock) begin
      inlock_d = 1'b0;
      outlock_d = 1'b0;
    end
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      lock_prev_q <= 1'b0;
      inlock_q <= 1'b0;
      outlock_q <= 1'b0;
    end else begin
      lock_prev_q <= lock_out;
      inlock_q <= inlock_d;
      outlock_q <= outlock_d;
    end
  end

  assign flag_any_out = inlock_q || outlock_q;

  ////////////////////////////////////////////////////////////////////////////
  // read port: only the status register answers, write-only ones read zero
  always @(posedge clk_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
      rvalid_out <= 1'b0;
    end else begin
      rvalid_out <= rd_en_in;
      if (rd_st) begin
        rdata_out <= {8'h00, lock_out, 5'h00, inlock_q, outlock_q};
      end else begin
        rdata_out <= 16'h0000;
      end
    end
  end

endmodule

/* File: sim/fnd_host_model.sv */
// host model driving the register port of one synthesiser slice
`timescale 1ns/1ps
module fnd_host_model (
  // clock
  input wire clk_in,
  // read answer
  input wire [15:0] rdata_in,
  input wire rvalid_in,
  // register port
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // idle bus shows inverted leftovers so stale values never pass for fresh ones
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge clk_in);
    #1;
    wr_en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] q, output logic v);
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b1;
    addr_out = a;
    @(posedge clk_in);
    #1;
    rd_en_out = 1'b0;
    addr_out = ~a;
    q = rdata_in;
    v = rvalid_in;
  endtask
endmodule

/* File: sim/fnd_synth_ctrl_properties.sv */
// concurrent checks on the synthesiser slice ports
`timescale 1ns/1ps
`include "fnd_consts.vh"
module fnd_synth_ctrl_props (
  // clock and reset
  input wire clk_in,
  input wire rst_in,
  // register port
  input wire wr_en_in,
  input wire rd_en_in,
  input wire [7:0] addr_in,
  input wire [15:0] wdata_in,
  input wire [15:0] rdata_out,
  input wire rvalid_out,
  // divider and lock
  input wire [10:0] ratio_int_out,
  input wire [23:0] ratio_frac_out,
  input wire frac_mode_out,
  input wire power_up_out,
  input wire cp_enable_out,
  input wire fastlock_start_out,
  input wire lock_out,
  input wire flag_any_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire st_rd = rd_en_in && addr_in == `FND_S1_FLAGS;
  wire div_wr = wr_en_in && (addr_in == `FND_S1_INTDIV || addr_in == `FND_S1_FRACLO);
  wire stage_wr = wr_en_in && (addr_in == `FND_S1_INTDIV || addr_in == `FND_S1_FRACHI);
  wire frac_wr = wr_en_in && (addr_in == `FND_S1_FRACLO || addr_in == `FND_S1_FRACHI);
  wire [10:0] wint = wdata_in[10:0];
  ////////////////////////////////////////////////////////////////
  AST_RSVD: assert property (st_rd |=> rvalid_out && rdata_out[6:2] == 5'h00)
    else $error("reserved status bits set");
  AST_LOCK: assert property (st_rd |=> rdata_out[7] == $past(lock_out))
    else $error("status lock bit wrong");
  AST_OR: assert property (st_rd |=> (rdata_out[1] | rdata_out[0]) == $past(flag_any_out))
    else $error("flag summary wrong");
  AST_RSTLK: assert property (wr_en_in && addr_in == `FND_S1_LOCKDET && wdata_in[13]
    |=> !flag_any_out)
    else $error("reset lock left a flag");
  AST_CP: assert property (cp_enable_out |-> power_up_out)
    else $error("charge pump on while powered down");
  AST_CPUP: assert property ($rose(cp_enable_out) |-> !$past(power_up_out) || $past(div_wr))
    else $error("charge pump on before divider load");
  AST_FLK: assert property (fastlock_start_out |-> $past(div_wr))
    else $error("fastlock without ratio change");
  AST_INT: assert property (!frac_mode_out && wr_en_in && addr_in == `FND_S1_INTDIV
    |=> ratio_int_out == $past(wint))
    else $error("integer write not applied");
  AST_STAGE: assert property (frac_mode_out && stage_wr
    |=> $stable(ratio_int_out) && $stable(ratio_frac_out))
    else $error("staged write changed ratio");
  AST_IGN: assert property (!frac_mode_out && frac_wr
    |=> $stable(ratio_int_out) && $stable(ratio_frac_out))
    else $error("fraction write changed integer ratio");
  cover property (fastlock_start_out);
  cover property (st_rd ##1 rdata_out[1]);
  cover property ($rose(cp_enable_out));
endmodule

/* File: sim/fracn_divider_lock_status_tb_top.sv */
// self-checking bench for one synthesiser slice and its host model
`timescale 1ns/1ps
`include "fnd_consts.vh"
module fracn_divider_lock_status_tb_top;
  typedef struct packed {logic [15:0] con, idv, lo; logic [7:0] hi; logic [23:0] ef;} fnd_row_t;
  fnd_row_t rows [3];
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic analog_lock_in = 1'b0;
  logic in_phase_in = 1'b0;
  logic out_phase_in = 1'b0;
  logic [15:0] q;
  logic v;
  logic [10:0] prev;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  wire wr_en_in, rd_en_in, rvalid_out, power_up_out, cp_enable_out, frac_mode_out;
  wire [3:0] cp_current_out;
  wire [6:0] ref_div_out;
  wire [11:0] fastacq_cfg_out;
  wire fastlock_start_out, lock_out, flag_any_out;
  wire [7:0] addr_in;
  wire [15:0] wdata_in, rdata_out;
  wire [10:0] ratio_int_out;
  wire [23:0] ratio_frac_out;
  fnd_synth_ctrl #(.SYNTH_SEL(1)) fnd_synth_ctrl_i (.clk_in, .rst_in, .wr_en_in, .rd_en_in,
    .addr_in, .wdata_in, .rdata_out, .rvalid_out, .analog_lock_in, .in_phase_in,
    .dummy_unused_out(), .out_phase_in, .ratio_int_out, .ratio_frac_out,
    .frac_mode_out, .power_up_out, .cp_enable_out, .cp_current_out, .ref_div_out,
    .fastacq_cfg_out, .fastlock_start_out, .lock_out, .flag_any_out);
  fnd_host_model fnd_host_model_i (.clk_in, .rdata_in(rdata_out), .rvalid_in(rvalid_out),
    .wr_en_out(wr_en_in), .rd_en_out(rd_en_in), .addr_out(addr_in), .wdata_out(wdata_in));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic rs(input logic [7:0] e);
    fnd_host_model_i.rd(`FND_S1_FLAGS, q, v);
    chk(q, {16'h0000, e});
    chk(v, 1'b1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ceiling is many times the length of the sequence below
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    rows[0] = '{16'h0100, 16'h0100, 16'h25ed, 8'h2c, 24'h000000};
    rows[1] = '{16'h4900, 16'h014f, 16'ha2ab, 8'h7f, 24'ha2ab00};
    rows[2] = '{16'h3100, 16'h03e4, 16'h25ed, 8'h2c, 24'h2c25ed};
    tick(3);
    rst_in = 1'b0;
    fnd_host_model_i.wr(`FND_S1_FASTACQ, 16'h1235);
    fnd_host_model_i.wr(`FND_S1_LOCKDET, 16'h4000);
    fnd_host_model_i.wr(`FND_S1_REFDIV, 16'h0008);
    fnd_host_model_i.wr(`FND_S1_CONTROL, 16'h0105);
    chk(power_up_out, 1'b1);
    chk(cp_enable_out, 1'b0);
    chk(cp_current_out, 4'h5);
    chk(ref_div_out, 7'h08);
    chk(fastacq_cfg_out, 12'h235);
    prev = 11'h020;
    for (int i = 0; i < 3; i++) begin
      fnd_host_model_i.wr(`FND_S1_CONTROL, rows[i].con);
      chk(frac_mode_out, rows[i].con[13:11] != 3'h0);
      fnd_host_model_i.wr(`FND_S1_INTDIV, rows[i].idv);
      chk(fastlock_start_out, rows[i].con[13:11] == 3'h0);
      if (rows[i].con[13:11] == 3'h0) chk(ratio_int_out, rows[i].idv[10:0]);
      fnd_host_model_i.wr(`FND_S1_FRACHI, {8'h00, rows[i].hi});
      if (rows[i].con[13:11] != 3'h0) chk(ratio_int_out, prev);
      fnd_host_model_i.wr(`FND_S1_FRACLO, rows[i].lo);
      chk(ratio_int_out, rows[i].idv[10:0]);
      chk(ratio_frac_out, rows[i].ef);
      chk(fastlock_start_out, rows[i].con[13:11] != 3'h0);
      chk(cp_enable_out, 1'b1);
      prev = rows[i].idv[10:0];
    end
    // edge mode with both flags enabled
    fnd_host_model_i.wr(`FND_S1_CONTROL, 16'h3160);
    fnd_host_model_i.wr(`FND_S1_LOCKDET, 16'h6000);
    rs(8'h00);
    analog_lock_in = 1'b1;
    tick(2);
    rs(8'h82);
    rs(8'h80);
    analog_lock_in = 1'b0;
    tick(2);
    chk(flag_any_out, 1'b1);
    rs(8'h01);
    rs(8'h00);
    // level mode
    fnd_host_model_i.wr(`FND_S1_CONTROL, 16'h3170);
    tick(2);
    rs(8'h01);
    rs(8'h01);
    analog_lock_in = 1'b1;
    tick(2);
    rs(8'h83);
    rs(8'h82);
    fnd_host_model_i.wr(`FND_S1_LOCKDET, 16'h6000);
    chk(flag_any_out, 1'b0);
    fnd_host_model_i.wr(`FND_S1_CONTROL, 16'h3130);
    rs(8'h82);
    rs(8'h80);
    // unmapped and write-only places read as zero
    fnd_host_model_i.rd(8'h60, q, v);
    chk(q, 24'h0);
    chk(v, 1'b1);
    fnd_host_model_i.rd(`FND_S1_FRACLO, q, v);
    chk(q, 24'h0);
    // digital detector with a threshold of three pulses
    fnd_host_model_i.wr(`FND_S1_LOCKDET, 16'h0003);
    chk(lock_out, 1'b0);
    in_phase_in = 1'b1;
    tick(2);
    chk(lock_out, 1'b0);
    tick(1);
    in_phase_in = 1'b0;
    chk(lock_out, 1'b1);
    // a zero loss field stands for eight out-of-phase pulses
    out_phase_in = 1'b1;
    tick(7);
    chk(lock_out, 1'b1);
    tick(1);
    out_phase_in = 1'b0;
    chk(lock_out, 1'b0);
    // reset in mid-run
    rst_in = 1'b1;
    tick(1);
    rst_in = 1'b0;
    chk(ratio_int_out, 11'h020);
    chk(cp_enable_out, 1'b0);
    chk(flag_any_out, 1'b0);
    chk(lock_out, 1'b0);
    // a load without the power-up bit must leave the charge pump off
    fnd_host_model_i.wr(`FND_S1_INTDIV, 16'h0040);
    chk(ratio_int_out, 11'h040);
    chk(cp_enable_out, 1'b0);
    tally_and_finish();
  end
endmodule
bind fnd_synth_ctrl fnd_synth_ctrl_props fnd_synth_ctrl_props_i (.clk_in, .rst_in, .wr_en_in,
  .rd_en_in, .addr_in, .wdata_in, .rdata_out, .rvalid_out, .ratio_int_out, .ratio_frac_out,
  .frac_mode_out, .power_up_out, .cp_enable_out, .fastlock_start_out, .lock_out, .flag_any_out);
